// ---- rtl/psr_params.svh ----
// Constants for the parallel service request and daisy-chain block.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// ****************************************************************
// Acknowledge cycle addressing and timing
// ****************************************************************
// Address width of the CPU address bus.
`define PSR_ADDR_W 7
// Address that marks a parallel service acknowledge (plain default).
`define PSR_ACK_ADDR 7'h00
// Clock cycles from the cycle start to cycle done.
`define PSR_DONE_DLY 2

`endif

// ---- rtl/psr_pkg.sv ----
// Types shared by the service request block.
package psr_pkg;
    // States of the acknowledge cycle sequencer.
    typedef enum logic [1:0] {
        PSR_IDLE,
        PSR_WAIT,
        PSR_DONE
    } psr_state_t;
endpackage : psr_pkg

// ---- rtl/psr_sync.sv ----
// Three-stage synchroniser for one asynchronous input pin.
module psr_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_val,
    input wire logic pin,
    output logic level
);
    // Stages one to three; stage one feeds only stage two.
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // Shift and accept a change once stages two and three agree.
    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
        if (srst) begin
            next_stage = {3{rst_val}};
            next_level = rst_val;
        end
    end

    // Register only.
    always_ff @(posedge clk) begin
        stage <= next_stage;
        level <= next_level;
    end
endmodule : psr_sync

// ---- rtl/psr_daisy.sv ----
// Parallel service request and daisy-chain acknowledge logic.
`include "psr_params.svh"
module psr_daisy (
    input wire logic clk,
    input wire logic srst,
    input wire logic negotiation_event,
    input wire logic direction_event,
    input wire logic fifo_event,
    input wire logic par_service_ack_n,
    input wire logic chain_grant_in_n,
    input wire logic cpu_strobe_n,
    input wire logic [`PSR_ADDR_W-1:0] cpu_addr,
    output logic par_service_request_n_o,
    output logic par_service_request_n_oe,
    output logic chain_pass_out_n,
    output logic cycle_done_n,
    output logic ack_taken
);
    // ****************************************************************
    // Block overview
    // ****************************************************************
    // The block keeps one pending flag that only the two port events
    // set. While the flag is set the open-drain request pin is pulled
    // low, and the external pull-up brings it back high otherwise.
    // The CPU side answers with an acknowledge cycle: acknowledge,
    // daisy grant and data strobe all low, with the service address
    // on the address bus.
    // The three strobes come from outside the clock domain, so each
    // passes a three-stage synchroniser first. This costs three to
    // four clocks of latency per edge, which is cheap against the
    // cycle times of the CPU bus and removes any metastability risk.
    // The address bus is only registered once: the CPU holds it
    // stable for the whole strobe, and the strobe itself lags by
    // three clocks, so the registered address has long settled when
    // the qualified strobe is seen.
    // When the cycle is accepted the flag clears unless a port event
    // comes in the same clock, ack_taken pulses for one clock and cycle
    // done goes low after a short fixed delay.
    // Cycle done stays low until the strobe is released, so the CPU
    // may stretch its cycle for as long as it wants.
    // A block without a pending flag hands the grant on through the
    // daisy pass output instead, so a chain of such blocks serves the
    // requester nearest to the CPU first.
    // Limitation: the FIFO event input is only watched by an
    // assertion here; FIFO service belongs on the DMA request path.
    // Limitation: once the request clears, the pass output may open
    // later in the same acknowledge cycle; a chained block only sees
    // that if the CPU keeps its acknowledge low, which it should not.

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The down counter is two bits wide, so the done delay must lie
    // between one and four clocks; anything else would wrap silently.
    if (`PSR_DONE_DLY < 1 || `PSR_DONE_DLY > 4) begin : g_bad_dly
        $error("Done delay does not fit the cycle counter");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Filtered, active-low pin levels.
    logic ack_n_s;
    logic grant_n_s;
    logic strobe_n_s;
    // Address is held stable by the CPU during the strobe.
    logic [`PSR_ADDR_W-1:0] addr_q;

    psr_sync u_ack (.clk(clk), .srst(srst), .rst_val(1'b1),
        .pin(par_service_ack_n), .level(ack_n_s));
    psr_sync u_grant (.clk(clk), .srst(srst), .rst_val(1'b1),
        .pin(chain_grant_in_n), .level(grant_n_s));
    psr_sync u_strobe (.clk(clk), .srst(srst), .rst_val(1'b1),
        .pin(cpu_strobe_n), .level(strobe_n_s));

    // ****************************************************************
    // Request and acknowledge sequencer
    // ****************************************************************
    // Pending request flag; set by port events only.
    logic pending;
    logic next_pending;
    psr_pkg::psr_state_t state;
    psr_pkg::psr_state_t next_state;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic pass_n;
    logic next_pass_n;
    logic done_n;
    logic next_done_n;
    logic taken;
    logic next_taken;
    logic [`PSR_ADDR_W-1:0] next_addr;
    // Qualified acknowledge: grant, strobe, acknowledge and address.
    logic qualified;

    always_comb begin
        qualified = !grant_n_s && !strobe_n_s && !ack_n_s
            && (addr_q == `PSR_ACK_ADDR);
    end

    // Next-state logic for the request, pass and done outputs.
    always_comb begin
        next_addr = cpu_addr;
        next_state = state;
        next_cnt = cnt;
        next_taken = 1'b0;
        next_done_n = done_n;
        // The FIFO event is deliberately unused here; it belongs on the
        // DMA request path.
        next_pending = pending || negotiation_event
            || direction_event;
        // Pass the grant only when nothing is pending here.
        next_pass_n = !(!ack_n_s && !grant_n_s && !pending);
        unique case (state)
            psr_pkg::PSR_IDLE: begin
                if (qualified && pending) begin
                    next_state = psr_pkg::PSR_WAIT;
                    next_cnt = 2'(`PSR_DONE_DLY - 1);
                    next_taken = 1'b1;
                    // Service clears; a new event in this cycle re-sets.
                    next_pending = negotiation_event || direction_event;
                end
            end
            psr_pkg::PSR_WAIT: begin
                next_cnt = cnt - 2'd1;
                if (cnt == 2'd0) begin
                    next_state = psr_pkg::PSR_DONE;
                    next_done_n = 1'b0;
                end
            end
            psr_pkg::PSR_DONE: begin
                if (strobe_n_s) begin
                    next_state = psr_pkg::PSR_IDLE;
                    next_done_n = 1'b1;
                end
            end
            // The fourth code of the state register is illegal; fall
            // back to idle and release cycle done should it appear.
            default: begin
                next_state = psr_pkg::PSR_IDLE;
                next_done_n = 1'b1;
            end
        endcase
        if (srst) begin
            next_state = psr_pkg::PSR_IDLE;
            next_cnt = 2'd0;
            next_pending = 1'b0;
            next_pass_n = 1'b1;
            next_done_n = 1'b1;
            next_taken = 1'b0;
            next_addr = '0;
        end
    end

    // Register only.
    always_ff @(posedge clk) begin
        state <= next_state;
        cnt <= next_cnt;
        pending <= next_pending;
        pass_n <= next_pass_n;
        done_n <= next_done_n;
        taken <= next_taken;
        addr_q <= next_addr;
    end

    // Open-drain request: drive low while pending.
    assign par_service_request_n_o = 1'b0;
    assign par_service_request_n_oe = pending;
    assign chain_pass_out_n = pass_n;
    assign cycle_done_n = done_n;
    assign ack_taken = taken;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_FIFO_NO_REQ: assert property (@(posedge clk) disable iff (srst)
        (fifo_event && !negotiation_event && !direction_event && !pending
         && !$past(srst)) |=> !pending)
        else $error("FIFO event raised service request");
    AST_EVENT_REQ: assert property (@(posedge clk) disable iff (srst)
        negotiation_event |=> par_service_request_n_oe)
        else $error("Port event did not raise request");
    AST_START: assert property (@(posedge clk) disable iff (srst)
        ack_taken |-> $past(qualified))
        else $error("Cycle started without qualification");
    AST_PASS: assert property (@(posedge clk) disable iff (srst)
        (!ack_n_s && !grant_n_s && !pending) |=> !chain_pass_out_n)
        else $error("Grant not passed on");
    AST_HOLD: assert property (@(posedge clk) disable iff (srst)
        pending |=> chain_pass_out_n)
        else $error("Pass active while request held");
    AST_RELEASE: assert property (@(posedge clk) disable iff (srst)
        ack_n_s |=> chain_pass_out_n)
        else $error("Pass not released");
    AST_DONE: assert property (@(posedge clk) disable iff (srst)
        ack_taken |-> ##2 !cycle_done_n)
        else $error("Cycle done late");
    AST_ADDR: assert property (@(posedge clk) disable iff (srst)
        ack_taken |-> $past(addr_q) == `PSR_ACK_ADDR)
        else $error("Acknowledge with wrong address");
    // A cycle is only accepted while a request is pending here.
    AST_NEED_REQ: assert property (@(posedge clk) disable iff (srst)
        ack_taken |-> $past(pending))
        else $error("Cycle accepted with no request pending");
    // Acceptance clears the request unless a new event came with it.
    AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
        (ack_taken && !$past(negotiation_event)
         && !$past(direction_event)) |-> !pending)
        else $error("Request not cleared by service");
    // Cycle done stands while the strobe is still held low.
    AST_DONE_HOLD: assert property (@(posedge clk) disable iff (srst)
        (!cycle_done_n && !strobe_n_s) |=> !cycle_done_n)
        else $error("Cycle done dropped during strobe");
    // Cycle done ends once the strobe has been released.
    AST_DONE_END: assert property (@(posedge clk) disable iff (srst)
        (!cycle_done_n && strobe_n_s) |=> cycle_done_n)
        else $error("Cycle done held after strobe");
endmodule : psr_daisy

// ---- testbench/psr_cpu_model.sv ----
// CPU-side acknowledge and daisy grant model facing the block.
`include "psr_params.svh"
module psr_cpu_model (
    input wire logic clk,
    input wire logic req_seen,
    input wire logic cycle,
    input wire logic grant,
    input wire logic strobe,
    input wire logic force_ack,
    input wire logic wrong_addr,
    output logic ack_n,
    output logic grant_n,
    output logic strobe_n,
    output logic [`PSR_ADDR_W-1:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Pins change just after an edge and hold for the whole cycle.
    // ************************************************************
    // Acknowledge is latched, so it stays low once the request clears.
    always_ff @(posedge clk) begin
        ack_n <= !cycle || (ack_n && !(req_seen || force_ack));
        grant_n <= !(cycle && grant);
        strobe_n <= !(cycle && strobe);
        // Outside a cycle, or when asked, the bus shows the inverse.
        addr <= (cycle && !wrong_addr) ? `PSR_ACK_ADDR
            : ~`PSR_ACK_ADDR;
    end
endmodule : psr_cpu_model

// ---- testbench/tb_parallel_service_request_daisy_chain.sv ----
// Self-checking bench for the service request and daisy-chain block.
`include "psr_params.svh"
module tb_parallel_service_request_daisy_chain;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic neg = 1'b0, dir = 1'b0, ffo = 1'b0;
    logic cyc = 1'b0, gnt = 1'b0, stb = 1'b0, frc = 1'b0, bad = 1'b0;
    logic ack_n, gnt_n, stb_n, o_n, oe, pass_n, done_n, taken;
    logic [`PSR_ADDR_W-1:0] adr;
    int bad_count = 0;
    int total_checks = 0;
    // The clock toggles every half period of 20 ns.
    always #20 clk = ~clk;
    psr_cpu_model i_cpu (.clk(clk), .req_seen(oe), .cycle(cyc),
        .grant(gnt), .strobe(stb), .force_ack(frc), .wrong_addr(bad),
        .ack_n(ack_n),
        .grant_n(gnt_n), .strobe_n(stb_n), .addr(adr));
    psr_daisy i_dut (.clk(clk), .srst(srst), .negotiation_event(neg),
        .direction_event(dir), .fifo_event(ffo), .par_service_ack_n(ack_n),
        .chain_grant_in_n(gnt_n), .cpu_strobe_n(stb_n), .cpu_addr(adr),
        .par_service_request_n_o(o_n), .par_service_request_n_oe(oe),
        .chain_pass_out_n(pass_n), .cycle_done_n(done_n),
        .ack_taken(taken));
    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic check(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Waits a bounded time; a stuck output ends the run.
    task automatic await(ref logic sig, input logic lvl);
        for (int i = 0; i < 20 && sig !== lvl; i++) tick(1);
        check(sig, lvl);
        if (sig !== lvl) conclude();
    endtask : await
    // Events are one-clock pulses: negotiation, direction, FIFO.
    task automatic pulse(input logic [2:0] sel);
        @(posedge clk) {neg, dir, ffo} <= sel;
        @(posedge clk) {neg, dir, ffo} <= 3'h0;
        tick(1);
    endtask : pulse
    // Cycle, grant, strobe and forced acknowledge, in that order.
    task automatic drive(input logic [3:0] v);
        @(posedge clk) {cyc, gnt, stb, frc} <= v;
        tick(1);
    endtask : drive
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic t_fifo();
        pulse(3'h1);
        tick(4);
        check(oe, 1'b0);
        $display("fifo test done");
    endtask : t_fifo
    // A pending request with no strobe must neither start nor pass.
    task automatic t_hold();
        pulse(3'h2);
        check(oe, 1'b1);
        drive(4'hc);
        tick(8);
        check(pass_n, 1'b1);
        check(oe, 1'b1);
        drive(4'h0);
        tick(6);
        $display("hold test done");
    endtask : t_hold
    // Acknowledge with a wrong address, or grant and strobe with the cycle bit off, is ignored.
    task automatic t_refuse();
        pulse(3'h2);
        check(oe, 1'b1);
        @(posedge clk) bad <= 1'b1;
        drive(4'he);
        tick(8);
        check(oe, 1'b1);
        check(done_n, 1'b1);
        drive(4'h0);
        @(posedge clk) bad <= 1'b0;
        drive(4'h6);
        tick(8);
        check(oe, 1'b1);
        check(done_n, 1'b1);
        drive(4'h0);
        tick(6);
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_serve();
        pulse(3'h4);
        check(oe, 1'b1);
        drive(4'he);
        await(taken, 1'b1);
        check(oe, 1'b0);
        await(done_n, 1'b0);
        drive(4'hc);
        await(done_n, 1'b1);
        drive(4'h0);
        await(pass_n, 1'b1);
        $display("serve test done");
    endtask : t_serve
    task automatic t_pass();
        drive(4'hd);
        await(pass_n, 1'b0);
        check(oe, 1'b0);
        drive(4'h0);
        await(pass_n, 1'b1);
        $display("pass test done");
    endtask : t_pass
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        tick(4);
        t_fifo();
        t_hold();
        t_refuse();
        t_serve();
        t_pass();
        conclude();
    end
endmodule : tb_parallel_service_request_daisy_chain
